// *** hw/rais_pkg.sv ***
// Constants and types shared by the reset and interrupt sequencer
package rais_pkg;
  localparam int NUM_VECTORS = 14;
  localparam int PRI_WIDTH = 2;
  localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
  localparam logic [15:0] TRAP_VECTOR = 16'hFFFC;
  localparam logic [15:0] MASKABLE_VECTOR_TOP = 16'hFFFA;
  localparam int SHORT_DELAY_CYCLES = 256;
  localparam int LONG_DELAY_CYCLES = 4096;
  localparam int FETCH_CYCLES = 2;
  localparam int DELAY_WIDTH = 13;
  // Minimum reset output pulse, in ns, and the cycles it takes at 4 ns
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MIN_RESET_OUT_NS = 20000;
  localparam int MIN_RESET_OUT_CYCLES = (MIN_RESET_OUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] ADDR_SYS_INTEGRITY = 4'h0;
  localparam logic [3:0] ADDR_PRIORITY_BASE = 4'h1;
  localparam logic [3:0] ADDR_PENDING_LOW = 4'h5;
  localparam logic [3:0] ADDR_PENDING_HIGH = 4'h6;
  localparam logic [3:0] ADDR_ENABLE_LOW = 4'h7;
  localparam logic [3:0] ADDR_ENABLE_HIGH = 4'h8;
  localparam logic [3:0] ADDR_LEVEL = 4'h9;
  localparam int WATCHDOG_FLAG_BIT = 0;
  localparam logic [7:0] SYS_INTEGRITY_RESET = 8'h00;
  localparam logic [7:0] PRIORITY_RESET = 8'hFF;
  localparam logic [1:0] LEVEL_MAIN = 2'b10;
  localparam logic [1:0] LEVEL_ONE = 2'b01;
  localparam logic [1:0] LEVEL_TWO = 2'b00;
  localparam logic [1:0] LEVEL_DISABLE = 2'b11;
  localparam int LEVEL_HIGH_POS = 5;
  localparam int LEVEL_LOW_POS = 3;
  localparam logic [7:0] CCR_RESET = 8'hEA;
  typedef enum logic [2:0] {
    RST_ACTIVE = 3'b000,
    RST_DELAY = 3'b001,
    RST_FETCH = 3'b010,
    RUN = 3'b011,
    IRQ_WAIT = 3'b100,
    IRQ_STACK = 3'b101,
    IRQ_VECTOR = 3'b110
  } seq_state_e;
endpackage

// *** hw/priority_link.sv ***
// Interface carrying the arbiter's request and answer between modules
`timescale 1ns/1ps
`default_nettype none
interface priority_link #(parameter int N = 14);
  logic [N-1:0] request;
  logic [2*N-1:0] priority_field;
  logic [1:0] current_level;
  logic found;
  logic [$clog2(N)-1:0] winner;
  logic [1:0] winner_level;
  modport arbiter (input request, input priority_field, input current_level,
                   output found, output winner, output winner_level);
  modport client (output request, output priority_field, output current_level,
                  input found, input winner, input winner_level);
endinterface
`default_nettype wire

// *** hw/priority_arbiter.sv ***
// Picks one pending maskable vector by software then hardware priority
`timescale 1ns/1ps
`default_nettype none
module priority_arbiter #(
  parameter int N = 14
) (
  priority_link.arbiter link
);
  import rais_pkg::*;

  // Rank maps the level encoding onto a plain order: main 0 up to disable 3
  function automatic logic [1:0] rank(input logic [1:0] code);
    logic [1:0] r;
    r = 2'd0;
    unique case (code)
      LEVEL_MAIN: r = 2'd0;
      LEVEL_ONE: r = 2'd1;
      LEVEL_TWO: r = 2'd2;
      LEVEL_DISABLE: r = 2'd3;
    endcase
    return r;
  endfunction

  logic [1:0] best_rank;
  logic best_found;
  logic [$clog2(N)-1:0] best_index;
  logic [1:0] best_code;

  // Lower index is the higher hardware priority; strict compare keeps it on ties
  always_comb begin
    best_rank = 2'd0;
    best_found = 1'b0;
    best_index = '0;
    best_code = LEVEL_MAIN;
    for (int i = 0; i < N; i++) begin
      if (link.request[i] &&
          rank(link.priority_field[2*i +: 2]) > rank(link.current_level) &&
          (!best_found || rank(link.priority_field[2*i +: 2]) > best_rank)) begin
        best_found = 1'b1;
        best_rank = rank(link.priority_field[2*i +: 2]);
        best_index = i[$clog2(N)-1:0];
        best_code = link.priority_field[2*i +: 2];
      end
    end
  end

  assign link.found = best_found;
  assign link.winner = best_index;
  assign link.winner_level = best_code;
endmodule
`default_nettype wire

// *** hw/reset_and_interrupt_sequencer.sv ***
// Reset sequencer and nested interrupt entry for the 8-bit core
// Summary of operation
// - External pin and watchdog both trigger reset
// - Reset pin held low through delay
// - Reset handler address fetched from top vector
// - Active, 256/4096 delay, then vector fetch
// - Vector fetch lasts exactly two cycles
// - Oscillator keeps running during reset
// - External reset low detected without clock; the code samples the pin through two core_clk flops
// - Watchdog underflow drives pin low minimum width
// - Watchdog flag set by hardware, cleared writing zero
// - Current instruction finishes before interrupt entry
// - Entry stacks program counter, index, accumulator, flags
// - Entry loads level from vector priority
// - Program counter loaded with serviced vector
// - Return restores saved level from stack
// - Level codes 10,01,00,11 mean 0..3
// - Highest software, then hardware priority wins
// - Unserviced requests stay latched pending
// - Unique hardware priority gives single winner
// - Reset and trap outrank all maskable sources
// - Sixteen vectors at top, ordered by priority
// - Maskable needs enable and strictly higher level
// - Non-maskable entry sets level three
// - Level-0 writes to priority fields ignored
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module reset_and_interrupt_sequencer #(
  parameter int N = rais_pkg::NUM_VECTORS,
  parameter int LONG_DELAY = rais_pkg::LONG_DELAY_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic watchdog_underflow,
  input wire logic long_delay_option,
  output logic oscillator_enable,
  output logic core_reset,
  input wire logic [N-1:0] irq_level,
  input wire logic [N-1:0] irq_edge_pulse,
  input wire logic trap_request,
  input wire logic instruction_boundary,
  input wire logic return_from_handler,
  input wire logic [7:0] stacked_condition_code,
  input wire logic [15:0] program_counter,
  input wire logic [7:0] index_x,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] condition_code_register,
  output logic stack_push,
  output logic [7:0] stack_data,
  output logic load_program_counter,
  output logic [15:0] vector_address,
  output logic [1:0] priority_level,
  output logic handler_start,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata
);
  import rais_pkg::*;

  localparam int IDX_W = $clog2(N);
  localparam int PRIO_REGS = (N + 3) / 4;

  seq_state_e state;
  seq_state_e next_state;

  // Own pull delayed like the pin, so it never reads as a cause
  logic pin_meta;
  logic pin_sync;
  logic drive_meta;
  logic drive_sync;
  logic ext_reset_seen;
  logic watchdog_reset;
  logic [DELAY_WIDTH-1:0] delay_count;
  logic [DELAY_WIDTH-1:0] delay_target;
  logic [15:0] pulse_count;
  logic cause_active;
  logic [1:0] fetch_count;

  logic [7:0] sys_integrity;
  logic [2*N-1:0] priority_field;
  logic [N-1:0] pending;
  logic [N-1:0] enable;
  logic [1:0] level;
  logic [2:0] stack_step;
  logic trap_pending;
  logic trap_taken;
  logic [IDX_W-1:0] serviced;
  logic [1:0] serviced_level;
  logic take_entry;

  priority_link #(.N(N)) arb_link ();

  priority_arbiter #(.N(N)) arbiter (
    .link(arb_link.arbiter)
  );

  assign arb_link.request = pending & enable;
  assign arb_link.priority_field = priority_field;
  assign arb_link.current_level = level;

  // A low reset_n loads the pin flops with 0 and the drive flops with 1 at once; the pin itself is sampled on core_clk
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      drive_meta <= 1'b1;
      drive_sync <= 1'b1;
    end else begin
      pin_meta <= reset_pin_in;
      pin_sync <= pin_meta;
      drive_meta <= reset_pin_oe;
      drive_sync <= drive_meta;
    end
  end

  assign ext_reset_seen = !pin_sync && !drive_sync;
  assign cause_active = ext_reset_seen || watchdog_underflow || (pulse_count != 16'd0);
  assign delay_target = long_delay_option ? DELAY_WIDTH'(LONG_DELAY - 1)
                                          : DELAY_WIDTH'(SHORT_DELAY_CYCLES - 1);

  // Watchdog underflow stretches into a minimum-width pin pulse
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_count <= 16'd0;
    end else if (watchdog_underflow) begin
      pulse_count <= 16'(MIN_RESET_OUT_CYCLES);
    end else if (pulse_count != 16'd0) begin
      pulse_count <= pulse_count - 16'd1;
    end
  end
  assign watchdog_reset = watchdog_underflow;

  always_comb begin
    next_state = state;
    unique case (state)
      RST_ACTIVE: if (!cause_active) next_state = RST_DELAY;
      RST_DELAY: begin
        if (cause_active) begin
          next_state = RST_ACTIVE;
        end else if (delay_count == delay_target) begin
          next_state = RST_FETCH;
        end
      end
      RST_FETCH: begin
        if (cause_active) begin
          next_state = RST_ACTIVE;
        end else if (fetch_count == 2'(FETCH_CYCLES - 1)) begin
          next_state = RUN;
        end
      end
      RUN: if (cause_active) next_state = RST_ACTIVE; else if (take_entry) next_state = IRQ_STACK;
      IRQ_STACK: begin
        if (cause_active) begin
          next_state = RST_ACTIVE;
        end else if (stack_step == 3'd4) begin
          next_state = IRQ_VECTOR;
        end
      end
      IRQ_VECTOR: next_state = cause_active ? RST_ACTIVE : RUN;
      default: next_state = RST_ACTIVE;
    endcase
  end

  // Trap and maskable entry only at an instruction boundary
  assign take_entry = instruction_boundary && (trap_pending || arb_link.found);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= RST_ACTIVE;
      delay_count <= '0;
      fetch_count <= 2'd0;
    end else begin
      state <= next_state;
      delay_count <= (state == RST_DELAY && !cause_active) ? delay_count + 1'b1 : '0;
      fetch_count <= (state == RST_FETCH) ? fetch_count + 2'd1 : 2'd0;
    end
  end

  // Pin stays driven low until the delay ends, whatever the cause
  assign reset_pin_oe = (state == RST_ACTIVE) || (state == RST_DELAY) || (pulse_count != 16'd0);
  assign reset_pin_out = 1'b0;
  assign oscillator_enable = 1'b1;
  assign core_reset = (state == RST_ACTIVE) || (state == RST_DELAY);

  // Watchdog flag: set wins over a clearing write in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_integrity <= SYS_INTEGRITY_RESET;
    end else if (watchdog_reset) begin
      sys_integrity[WATCHDOG_FLAG_BIT] <= 1'b1;
    end else if (reg_write && reg_addr == ADDR_SYS_INTEGRITY && !reg_wdata[WATCHDOG_FLAG_BIT]) begin
      sys_integrity[WATCHDOG_FLAG_BIT] <= 1'b0;
    end
  end

  // Priority fields: a level-0 code in any pair keeps the old pair
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      priority_field <= {N{LEVEL_DISABLE}};
    end else begin
      for (int r = 0; r < PRIO_REGS; r++) begin
        if (reg_write && reg_addr == 4'(ADDR_PRIORITY_BASE + r)) begin
          for (int p = 0; p < 4; p++) begin
            if (4 * r + p < N && reg_wdata[2*p +: 2] != LEVEL_MAIN) begin
              priority_field[2*(4*r+p) +: 2] <= reg_wdata[2*p +: 2];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable <= '0;
    end else if (reg_write && reg_addr == ADDR_ENABLE_LOW) begin
      enable[7:0] <= reg_wdata;
    end else if (reg_write && reg_addr == ADDR_ENABLE_HIGH) begin
      enable[N-1:8] <= reg_wdata[N-9:0];
    end
  end

  // Pending latch; a new edge in the taking cycle survives the clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending <= '0;
      trap_pending <= 1'b0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (irq_edge_pulse[i] || irq_level[i]) begin
          pending[i] <= 1'b1;
        end else if (state == RUN && take_entry && !trap_pending && arb_link.winner == IDX_W'(i)) begin
          pending[i] <= 1'b0;
        end
      end
      if (trap_request) begin
        trap_pending <= 1'b1;
      end else if (state == RUN && take_entry && trap_pending) begin
        trap_pending <= 1'b0;
      end
    end
  end

  // Level follows reset, entry, and return; trap outranks maskable
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      level <= LEVEL_DISABLE;
      serviced <= '0;
      serviced_level <= LEVEL_DISABLE;
      trap_taken <= 1'b0;
      stack_step <= 3'd0;
    end else begin
      if (state == RUN && take_entry) begin
        trap_taken <= trap_pending;
        serviced <= arb_link.winner;
        serviced_level <= trap_pending ? LEVEL_DISABLE : arb_link.winner_level;
      end
      stack_step <= (state == IRQ_STACK) ? stack_step + 3'd1 : 3'd0;
      if (core_reset) begin
        level <= LEVEL_DISABLE;
      end else if (state == IRQ_VECTOR) begin
        level <= serviced_level;
      end else if (state == RUN && return_from_handler) begin
        level <= {stacked_condition_code[LEVEL_HIGH_POS], stacked_condition_code[LEVEL_LOW_POS]};
      end
    end
  end

  // Stack order: low PC, high PC, X, A, flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_push <= 1'b0;
      stack_data <= 8'h00;
    end else begin
      stack_push <= (state == IRQ_STACK);
      unique case (stack_step)
        3'd0: stack_data <= program_counter[7:0];
        3'd1: stack_data <= program_counter[15:8];
        3'd2: stack_data <= index_x;
        3'd3: stack_data <= accumulator;
        default: stack_data <= condition_code_register;
      endcase
    end
  end

  // Maskable vectors step down two bytes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_address <= RESET_VECTOR;
      load_program_counter <= 1'b0;
      handler_start <= 1'b0;
    end else begin
      load_program_counter <= (state == IRQ_VECTOR) || (state == RST_FETCH && next_state == RUN);
      handler_start <= load_program_counter;
      if (state == RST_FETCH || core_reset) begin
        vector_address <= RESET_VECTOR;
      end else if (state == IRQ_VECTOR) begin
        vector_address <= trap_taken ? TRAP_VECTOR
                        : MASKABLE_VECTOR_TOP - {11'd0, serviced, 1'b0};
      end
    end
  end

  assign priority_level = level;

  // Read data one cycle late; reserved bits zero, unused priority pairs read 11
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == ADDR_SYS_INTEGRITY) begin
      next_rdata = {7'd0, sys_integrity[WATCHDOG_FLAG_BIT]};
    end else if (reg_addr >= ADDR_PRIORITY_BASE && reg_addr < 4'(ADDR_PRIORITY_BASE + PRIO_REGS)) begin
      for (int r = 0; r < PRIO_REGS; r++) begin
        if (reg_addr == 4'(ADDR_PRIORITY_BASE + r)) begin
          for (int p = 0; p < 4; p++) begin
            next_rdata[2*p +: 2] = (4 * r + p < N) ? priority_field[2*((4*r+p) % N) +: 2] : LEVEL_DISABLE;
          end
        end
      end
    end else if (reg_addr == ADDR_PENDING_LOW) begin
      next_rdata = pending[7:0];
    end else if (reg_addr == ADDR_PENDING_HIGH) begin
      next_rdata = {{(16 - N){1'b0}}, pending[N-1:8]};
    end else if (reg_addr == ADDR_ENABLE_LOW) begin
      next_rdata = enable[7:0];
    end else if (reg_addr == ADDR_ENABLE_HIGH) begin
      next_rdata = {{(16 - N){1'b0}}, enable[N-1:8]};
    end else if (reg_addr == ADDR_LEVEL) begin
      next_rdata = {6'd0, level};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? next_rdata : 8'h00;
    end
  end
endmodule
`default_nettype wire

// *** tb/reset_and_interrupt_sequencer_monitor.sv ***
// Checker for reset and interrupt entry
`timescale 1ns/1ps
`default_nettype none
module rais_monitor
  import rais_pkg::*;
#(
  parameter int N = NUM_VECTORS,
  parameter int LONG_DELAY = LONG_DELAY_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic watchdog_underflow,
  input wire logic oscillator_enable,
  input wire logic core_reset,
  input wire logic instruction_boundary,
  input wire logic stack_push,
  input wire logic load_program_counter,
  input wire logic [15:0] vector_address,
  input wire logic [1:0] priority_level,
  input wire logic handler_start
);
  logic wd_seen;
  logic [15:0] oe_run;
  logic [1:0] entry_level;
  function automatic int rank(input logic [1:0] c);
    return (c == LEVEL_MAIN) ? 0 : (c == LEVEL_ONE) ? 1 : (c == LEVEL_TWO) ? 2 : 3;
  endfunction
  // Held until the pin is let go
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wd_seen <= 1'b0;
      oe_run <= 16'h0000;
      entry_level <= LEVEL_DISABLE;
    end else begin
      wd_seen <= watchdog_underflow | (wd_seen & !$fell(reset_pin_oe));
      oe_run <= reset_pin_oe ? oe_run + 16'h0001 : 16'h0000;
      if ($rose(stack_push)) begin
        entry_level <= priority_level;
      end
    end
  end
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  sequence push_burst;
    stack_push [*5] ##1 !stack_push;
  endsequence
  sequence vector_load;
    ##[0:2] load_program_counter ##1 handler_start;
  endsequence
  osc_running_a: assert property (oscillator_enable && !reset_pin_out)
    else $error("oscillator stopped or pin driven high");
  delay_pin_low_a: assert property (core_reset |-> reset_pin_oe)
    else $error("reset pin released during reset");
  reset_fetch_a: assert property ($fell(core_reset) |-> ##[1:3] (load_program_counter && vector_address == RESET_VECTOR))
    else $error("reset vector not fetched");
  watchdog_pin_a: assert property ($rose(watchdog_underflow) |-> ##[0:3] reset_pin_oe)
    else $error("watchdog did not pull pin");
  pulse_width_a: assert property ($fell(reset_pin_oe) && wd_seen |-> oe_run >= MIN_RESET_OUT_CYCLES)
    else $error("watchdog reset pulse too short");
  stack_five_a: assert property ($rose(stack_push) |-> push_burst)
    else $error("context push count wrong");
  stack_vector_a: assert property ($fell(stack_push) |-> vector_load)
    else $error("vector not loaded after stacking");
  entry_boundary_a: assert property ($rose(stack_push) |-> $past(instruction_boundary) || $past(instruction_boundary, 2))
    else $error("entry not at instruction boundary");
  trap_level_a: assert property (load_program_counter && vector_address == TRAP_VECTOR |-> priority_level == LEVEL_DISABLE)
    else $error("trap entry level wrong");
  masked_entry_a: assert property (load_program_counter && vector_address < TRAP_VECTOR |-> rank(priority_level) > rank(entry_level))
    else $error("maskable entry without higher level");
endmodule
bind reset_and_interrupt_sequencer rais_monitor #(.N(N), .LONG_DELAY(LONG_DELAY)) i_monitor (.core_clk, .reset_n,
  .reset_pin_out, .reset_pin_oe, .watchdog_underflow, .oscillator_enable, .core_reset, .instruction_boundary,
  .stack_push, .load_program_counter, .vector_address, .priority_level, .handler_start);
`default_nettype wire

// *** tb/cpu_model.sv ***
// Behavioural CPU core on the far side of the stacking and vector ports
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic stack_push,
  input wire logic [7:0] stack_data,
  input wire logic load_program_counter,
  input wire logic [15:0] vector_address,
  input wire logic [1:0] priority_level,
  output logic instruction_boundary,
  output logic [15:0] program_counter,
  output logic [7:0] index_x,
  output logic [7:0] accumulator,
  output logic [7:0] condition_code_register,
  output logic [39:0] frame
);
  logic [1:0] phase;
  assign condition_code_register = {2'b11, priority_level[1], 1'b0, priority_level[0], 3'b010};
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 2'd0;
      instruction_boundary <= 1'b0;
      program_counter <= 16'h8000;
      index_x <= 8'h5A;
      accumulator <= 8'hC3;
      frame <= 40'h0;
    end else begin
      phase <= (phase == 2'd2) ? 2'd0 : phase + 2'd1;
      // Slow mode stands for three-cycle instructions
      instruction_boundary <= !slow || phase == 2'd2;
      if (stack_push) begin
        frame <= {frame[31:0], stack_data};
      end
      if (load_program_counter) begin
        program_counter <= vector_address;
        index_x <= index_x + 8'h13;
        accumulator <= accumulator ^ vector_address[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/reset_and_interrupt_sequencer_tb.sv ***
// Bench for the reset and interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_and_interrupt_sequencer_tb;
  import rais_pkg::*;
  localparam int LD = 300;
  logic core_clk = 1'b0, reset_n = 1'b0, ext_low = 1'b0, watchdog_underflow = 1'b0, long_delay_option = 1'b0;
  logic trap_request = 1'b0, return_from_handler = 1'b0, reg_write = 1'b0, reg_read = 1'b0, slow = 1'b0;
  logic [NUM_VECTORS-1:0] irq_edge_pulse = '0;
  logic [7:0] stacked_condition_code = 8'h00, reg_wdata = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_rdata, stack_data, index_x, accumulator, ccr;
  logic [15:0] program_counter, vector_address;
  logic [1:0] priority_level, lvl;
  logic [39:0] frame;
  logic reset_pin_out, reset_pin_oe, oscillator_enable, core_reset, instruction_boundary, stack_push;
  logic load_program_counter, handler_start;
  wire reset_pin;
  int failures = 0, checked = 0, cycles = 0;
  logic [1:0] pri [NUM_VECTORS];
  logic [NUM_VECTORS-1:0] en, pend;
  // Open drain with pull-up: low if either side pulls
  assign reset_pin = reset_pin_oe ? reset_pin_out : !ext_low;
  reset_and_interrupt_sequencer #(.LONG_DELAY(LD)) i_dut (.core_clk, .reset_n, .reset_pin_in(reset_pin), .reset_pin_out,
    .reset_pin_oe, .watchdog_underflow, .long_delay_option, .oscillator_enable, .core_reset, .irq_level('0),
    .irq_edge_pulse, .trap_request, .instruction_boundary, .return_from_handler, .stacked_condition_code,
    .program_counter, .index_x, .accumulator, .condition_code_register(ccr), .stack_push, .stack_data,
    .load_program_counter, .vector_address, .priority_level, .handler_start, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata);
  cpu_model i_cpu (.core_clk, .reset_n, .slow, .stack_push, .stack_data, .load_program_counter, .vector_address,
    .priority_level, .instruction_boundary, .program_counter, .index_x, .accumulator, .condition_code_register(ccr),
    .frame);
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      results();
    end
  end
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  function automatic int rank(input logic [1:0] c);
    return (c == LEVEL_MAIN) ? 0 : (c == LEVEL_ONE) ? 1 : (c == LEVEL_TWO) ? 2 : 3;
  endfunction
  // Strict compare keeps the lower index on a tie
  function automatic int pick();
    int b = -1;
    for (int i = 0; i < NUM_VECTORS; i++)
      if (pend[i] && en[i] && rank(pri[i]) > rank(lvl) && (b < 0 || rank(pri[i]) > rank(pri[b]))) b = i;
    return b;
  endfunction
  task automatic wpri(input int r, input logic [7:0] d);
    wr(ADDR_PRIORITY_BASE + 4'(r), d);
    for (int k = 0; k < 4; k++)
      if (4 * r + k < NUM_VECTORS && d[2*k+:2] != LEVEL_MAIN) pri[4*r+k] = d[2*k+:2];
  endtask
  function automatic logic [7:0] ppack(input int r);
    logic [7:0] v = 8'hFF;
    for (int k = 0; k < 4; k++)
      if (4 * r + k < NUM_VECTORS) v[2*k+:2] = pri[4*r+k];
    return v;
  endfunction
  task automatic waitload(input int lim, output int n);
    n = 0;
    while (load_program_counter !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask
  task automatic boot(input int d);
    int n;
    waitload(9000, n);
    chk(n >= d && n <= d + 10, 1'b1);
    chk(vector_address, RESET_VECTOR);
    @(posedge core_clk);
    #1 chk(handler_start, 1'b1);
    lvl = LEVEL_DISABLE;
  endtask
  task automatic svc(input logic [15:0] vec, input logic [1:0] lv);
    logic [39:0] ctx;
    int n;
    ctx = {program_counter[7:0], program_counter[15:8], index_x, accumulator, ccr};
    waitload(80, n);
    chk(vector_address, vec);
    chk(priority_level, lv);
    chk(frame, ctx);
    @(posedge core_clk);
    #1 chk(handler_start, 1'b1);
    lvl = lv;
  endtask
  task automatic drain();
    int w = pick();
    while (w >= 0) begin
      svc(MASKABLE_VECTOR_TOP - 16'(2 * w), pri[w]);
      pend[w] = 1'b0;
      w = pick();
    end
    repeat (30) begin
      @(posedge core_clk);
      #1 chk(load_program_counter, 1'b0);
    end
  endtask
  task automatic ret(input logic [1:0] c);
    @(posedge core_clk);
    return_from_handler <= 1'b1;
    stacked_condition_code <= {2'b11, c[1], 1'b0, c[0], 3'b010};
    @(posedge core_clk);
    return_from_handler <= 1'b0;
    stacked_condition_code <= ~{2'b11, c[1], 1'b0, c[0], 3'b010};
    #1 chk(priority_level, c);
    lvl = c;
  endtask
  task automatic pulse(input logic [NUM_VECTORS-1:0] m);
    @(posedge core_clk);
    irq_edge_pulse <= m;
    @(posedge core_clk);
    irq_edge_pulse <= '0;
    pend = pend | m;
  endtask
  initial begin
    en = '0;
    pend = '0;
    for (int i = 0; i < NUM_VECTORS; i++) pri[i] = 2'b11;
    void'($urandom(85));
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    boot(SHORT_DELAY_CYCLES);
    chk(oscillator_enable, 1'b1);
    rd(ADDR_SYS_INTEGRITY, SYS_INTEGRITY_RESET);
    for (int k = 0; k < 4; k++) rd(ADDR_PRIORITY_BASE + 4'(k), PRIORITY_RESET);
    rd(4'hA, 8'h00);
    wr(4'hB, 8'hFF);
    wr(ADDR_PENDING_LOW, 8'hFF);
    rd(ADDR_PENDING_LOW, 8'h00);
    wpri(0, 8'hCF);
    wpri(0, 8'h64);
    rd(ADDR_PRIORITY_BASE, ppack(0));
    @(posedge core_clk);
    trap_request <= 1'b1;
    @(posedge core_clk);
    trap_request <= 1'b0;
    svc(TRAP_VECTOR, LEVEL_DISABLE);
    wr(ADDR_ENABLE_LOW, 8'hFF);
    wr(ADDR_ENABLE_HIGH, 8'h3F);
    en = '1;
    wpri(0, 8'hC1);
    pulse(14'h0007);
    ret(LEVEL_MAIN);
    drain();
    ret(LEVEL_MAIN);
    drain();
    ret(LEVEL_ONE);
    drain();
    rd(ADDR_PENDING_LOW, pend[7:0]);
    ret(LEVEL_MAIN);
    drain();
    for (int r = 0; r < 6; r++) begin
      ret(LEVEL_DISABLE);
      slow <= r[0];
      for (int k = 0; k < 4; k++) begin
        wpri(k, 8'($urandom));
        rd(ADDR_PRIORITY_BASE + 4'(k), ppack(k));
      end
      en = NUM_VECTORS'($urandom);
      wr(ADDR_ENABLE_LOW, en[7:0]);
      wr(ADDR_ENABLE_HIGH, {2'b00, en[13:8]});
      pulse(NUM_VECTORS'($urandom));
      ret(LEVEL_MAIN);
      drain();
      rd(ADDR_PENDING_LOW, pend[7:0]);
      rd(ADDR_PENDING_HIGH, {2'b00, pend[13:8]});
    end
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (100) @(posedge core_clk);
    watchdog_underflow <= 1'b1;
    @(posedge core_clk);
    watchdog_underflow <= 1'b0;
    boot(MIN_RESET_OUT_CYCLES + SHORT_DELAY_CYCLES);
    rd(ADDR_SYS_INTEGRITY, 8'h01);
    wr(ADDR_SYS_INTEGRITY, 8'h00);
    rd(ADDR_SYS_INTEGRITY, 8'h00);
    long_delay_option <= 1'b1;
    ext_low <= 1'b1;
    repeat (2) @(posedge core_clk);
    ext_low <= 1'b0;
    boot(LD);
    results();
  end
endmodule
`default_nettype wire
